/* common/adc_seq_pkg.sv */
// Constants and types for the converter sequencer control block
package adc_seq_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses, 16-bit registers)
  // ------------------------------------------------------------------
  localparam logic [15:0] RESULT_ADDR  = 16'h5380;
  localparam logic [15:0] TRIGGER_ADDR = 16'h5382;
  localparam logic [15:0] CONTROL_ADDR = 16'h5384;
  localparam logic [15:0] DIVIDER_ADDR = 16'h5386;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int LAST_CH_LSB    = 11;
  localparam int FIRST_CH_LSB   = 8;
  localparam int ALIGN_BIT      = 7;
  localparam int REPEAT_BIT     = 6;
  localparam int TRIG_LSB       = 4;
  localparam int SAMPLE_LSB     = 0;
  localparam int CUR_CH_LSB     = 12;
  localparam int BUSY_BIT       = 10;
  localparam int OVERRUN_BIT    = 9;
  localparam int DONE_BIT       = 8;
  localparam int OVR_IE_BIT     = 5;
  localparam int DONE_IE_BIT    = 4;
  localparam int RUN_BIT        = 1;
  localparam int ENABLE_BIT     = 0;
  localparam int RESULT_SHIFT   = 6;

  // ------------------------------------------------------------------
  // Reset values and encodings
  // ------------------------------------------------------------------
  localparam logic [2:0] SAMPLE_RESET   = 3'h7;
  localparam logic [3:0] PRESCALE_RESET = 4'h0;
  localparam logic [3:0] PRESCALE_RSVD  = 4'hF;
  localparam logic [1:0] TRIG_SOFTWARE  = 2'h0;
  localparam logic [1:0] TRIG_TIMER     = 2'h1;
  localparam logic [1:0] TRIG_PIN       = 2'h3;
  localparam logic [3:0] SAMPLE_EXTRA   = 4'h2;
  localparam logic [3:0] CONVERT_CYCLES = 4'hA;

  typedef enum logic [1:0] {
    IDLE,
    SAMPLE,
    CONVERT,
    CAPTURE
  } seq_state_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;

  typedef struct packed {
    seq_state_type state;
    logic [2:0]    first_channel;
    logic [2:0]    last_channel;
    logic          result_alignment;
    logic          repeat_select;
    logic [1:0]    trigger_source;
    logic [2:0]    sample_length;
    logic [2:0]    current_channel;
    logic          converter_busy;
    logic          overrun_flag;
    logic          done_flag;
    logic          overrun_irq_enable;
    logic          done_irq_enable;
    logic          run_stop;
    logic          converter_enable;
    logic [3:0]    prescale_select;
    logic [14:0]   prescale_count;
    logic          conv_tick;
    logic [3:0]    phase_count;
    logic [9:0]    result;
    logic          unread;
    logic          timer_last;
    logic          pin_last;
    logic [15:0]   rdata;
    logic          irq;
    logic          sample_out;
    logic          start_out;
  } state_type;

endpackage

/* src/adc_seq_ctrl.sv */
// Sequencer, prescaler and register file of the converter control block
// How it works
// - Alignment 0 puts result in bits 9..0, upper bits zero.
// - Alignment 1 puts result in bits 15..6, lower bits zero.
// - Alignment bit is D7 of trigger register, resets to 0.
// - Result register is 16-bit read-only, resets to zero.
// - First channel D10-8 and last channel D13-11, read/write, 0..7.
// - Control/status D14-12 shows channel being converted.
// - Trigger source D5-4: software, timer channel 0, reserved, pin.
// - Sampling lasts field plus two conversion clocks, resets to 7.
// - Overrun flag D9 set on unread result, cleared by writing 1.
// - Overrun interrupt only while D5 enable and flag both set.
// - Completion interrupt only while D4 enable and flag both set.
// - Divider field 0 gives 1/2, doubling to 1/32768; 0xF reserved.
// - Prescaler runs from bus clock, field resets to 0.
`timescale 1ns/1ns
module adc_seq_ctrl
  import adc_seq_pkg::*;
(
  input  wire logic                  CLK,
  input  wire logic                  NRST,
  input  wire adc_seq_pkg::bus_req_type BUS,
  output logic [15:0]                RDATA,
  output logic                       IRQ,
  input  wire logic                  TIMER_TRIGGER,
  input  wire logic                  EXTERNAL_TRIGGER_PIN,
  input  wire logic                  CORE_READY,
  input  wire logic [9:0]            CORE_DATA,
  output logic [2:0]                 CORE_CHANNEL,
  output logic                       CORE_SAMPLE,
  output logic                       CORE_START
);
  import adc_seq_pkg::*;

  state_type q;
  state_type d;

  logic wr_trig;
  logic wr_ctrl;
  logic wr_div;
  logic rd_result;
  logic trigger_seen;
  logic last_done;
  logic [15:0] aligned;
  logic [14:0] prescale_limit;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  assign wr_trig   = BUS.wr && BUS.addr == TRIGGER_ADDR;
  assign wr_ctrl   = BUS.wr && BUS.addr == CONTROL_ADDR;
  assign wr_div    = BUS.wr && BUS.addr == DIVIDER_ADDR;
  assign rd_result = BUS.rd && BUS.addr == RESULT_ADDR;

  assign prescale_limit = (q.prescale_select == PRESCALE_RSVD) ?
                          15'h7FFF :
                          15'((16'h0002 << q.prescale_select) - 16'h0001);

  assign aligned = q.result_alignment ?
                   {q.result, 6'h00} : {6'h00, q.result};

  always_comb begin
    unique case (q.trigger_source)
      TRIG_SOFTWARE: trigger_seen = 1'b1;
      TRIG_TIMER:    trigger_seen = TIMER_TRIGGER && !q.timer_last;
      TRIG_PIN:      trigger_seen = EXTERNAL_TRIGGER_PIN && !q.pin_last;
      default:       trigger_seen = 1'b0;
    endcase
  end

  assign last_done = q.current_channel == q.last_channel;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    d.timer_last = TIMER_TRIGGER;
    d.pin_last   = EXTERNAL_TRIGGER_PIN;
    d.start_out  = 1'b0;

    d.conv_tick = 1'b0;
    if (q.prescale_count >= prescale_limit) begin
      d.prescale_count = 15'h0000;
      d.conv_tick      = 1'b1;
    end else begin
      d.prescale_count = q.prescale_count + 15'h0001;
    end

    if (wr_trig) begin
      d.last_channel     = BUS.wdata[LAST_CH_LSB +: 3];
      d.first_channel    = BUS.wdata[FIRST_CH_LSB +: 3];
      d.result_alignment = BUS.wdata[ALIGN_BIT];
      d.repeat_select    = BUS.wdata[REPEAT_BIT];
      d.trigger_source   = BUS.wdata[TRIG_LSB +: 2];
      d.sample_length    = BUS.wdata[SAMPLE_LSB +: 3];
    end
    if (wr_ctrl) begin
      d.overrun_irq_enable = BUS.wdata[OVR_IE_BIT];
      d.done_irq_enable    = BUS.wdata[DONE_IE_BIT];
      d.run_stop           = BUS.wdata[RUN_BIT];
      d.converter_enable   = BUS.wdata[ENABLE_BIT];
      if (BUS.wdata[OVERRUN_BIT]) begin
        d.overrun_flag = 1'b0;
      end
    end
    if (wr_div) begin
      d.prescale_select = BUS.wdata[3:0];
      d.prescale_count  = 15'h0000;
    end

    if (rd_result) begin
      d.done_flag = 1'b0;
      d.unread    = 1'b0;
    end

    unique case (q.state)
      IDLE: begin
        d.converter_busy = 1'b0;
        if (q.converter_enable && q.run_stop && trigger_seen) begin
          d.state           = SAMPLE;
          d.current_channel = q.first_channel;
          d.phase_count     = 4'h0;
          d.converter_busy  = 1'b1;
          d.sample_out      = 1'b1;
        end
      end
      SAMPLE: begin
        if (q.conv_tick) begin
          if (q.phase_count + 4'h1 >=
              {1'b0, q.sample_length} + SAMPLE_EXTRA) begin
            d.state       = CONVERT;
            d.phase_count = 4'h0;
            d.sample_out  = 1'b0;
            d.start_out   = 1'b1;
          end else begin
            d.phase_count = q.phase_count + 4'h1;
          end
        end
      end
      CONVERT: begin
        if (CORE_READY) begin
          d.state = CAPTURE;
        end
      end
      CAPTURE: begin
        d.result = CORE_DATA;
        d.unread = 1'b1;
        if (q.unread && !rd_result) begin
          d.overrun_flag = 1'b1;
        end
        if (last_done) begin
          d.done_flag = 1'b1;
          if (q.repeat_select) begin
            d.state           = SAMPLE;
            d.current_channel = q.first_channel;
            d.sample_out      = 1'b1;
          end else begin
            d.state          = IDLE;
            d.run_stop       = 1'b0;
            d.converter_busy = 1'b0;
          end
        end else begin
          d.state           = SAMPLE;
          d.current_channel = q.current_channel + 3'h1;
          d.sample_out      = 1'b1;
        end
        d.phase_count = 4'h0;
      end
    endcase

    if ((wr_ctrl && !BUS.wdata[RUN_BIT]) ||
        (wr_ctrl && !BUS.wdata[ENABLE_BIT])) begin
      d.state          = IDLE;
      d.converter_busy = 1'b0;
      d.sample_out     = 1'b0;
      d.start_out      = 1'b0;
    end

    d.irq = (d.overrun_flag && d.overrun_irq_enable) ||
            (d.done_flag && d.done_irq_enable);

    d.rdata = 16'h0000;
    if (BUS.rd) begin
      unique case (BUS.addr)
        RESULT_ADDR:  d.rdata = aligned;
        TRIGGER_ADDR: begin
          d.rdata[LAST_CH_LSB +: 3]  = q.last_channel;
          d.rdata[FIRST_CH_LSB +: 3] = q.first_channel;
          d.rdata[ALIGN_BIT]         = q.result_alignment;
          d.rdata[REPEAT_BIT]        = q.repeat_select;
          d.rdata[TRIG_LSB +: 2]     = q.trigger_source;
          d.rdata[SAMPLE_LSB +: 3]   = q.sample_length;
        end
        CONTROL_ADDR: begin
          d.rdata[CUR_CH_LSB +: 3] = q.current_channel;
          d.rdata[BUSY_BIT]        = q.converter_busy;
          d.rdata[OVERRUN_BIT]     = q.overrun_flag;
          d.rdata[DONE_BIT]        = q.done_flag;
          d.rdata[OVR_IE_BIT]      = q.overrun_irq_enable;
          d.rdata[DONE_IE_BIT]     = q.done_irq_enable;
          d.rdata[RUN_BIT]         = q.run_stop;
          d.rdata[ENABLE_BIT]      = q.converter_enable;
        end
        DIVIDER_ADDR: d.rdata[3:0] = q.prescale_select;
        default:      d.rdata = 16'h0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      q                 <= '0;
      q.state           <= IDLE;
      q.sample_length   <= SAMPLE_RESET;
      q.prescale_select <= PRESCALE_RESET;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign RDATA        = q.rdata;
  assign IRQ          = q.irq;
  assign CORE_CHANNEL = q.current_channel;
  assign CORE_SAMPLE  = q.sample_out;
  assign CORE_START   = q.start_out;

endmodule

/* tb/adc_seq_ctrl_sva.sv */
// Port checker for the converter sequencer control block
`timescale 1ns/1ns
module adc_seq_ctrl_sva
  import adc_seq_pkg::*;
(
  input wire logic                     CLK,
  input wire logic                     NRST,
  input wire adc_seq_pkg::bus_req_type BUS,
  input wire logic [15:0]              RDATA,
  input wire logic                     IRQ,
  input wire logic                     CORE_SAMPLE,
  input wire logic                     CORE_START
);
  logic       align_q;
  logic [1:0] ie_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // Shadow of the alignment bit and both interrupt enables
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      align_q <= 1'b0;
      ie_q    <= 2'h0;
    end else if (BUS.wr && BUS.addr == TRIGGER_ADDR) begin
      align_q <= BUS.wdata[ALIGN_BIT];
    end else if (BUS.wr && BUS.addr == CONTROL_ADDR) begin
      ie_q <= BUS.wdata[OVR_IE_BIT:DONE_IE_BIT];
    end
  end
  sequence s_read(logic [15:0] a);
    BUS.rd && BUS.addr == a ##1 1'b1;
  endsequence
  sequence s_sampling;
    CORE_SAMPLE[*3];
  endsequence
  property p_quiet;
    !$past(BUS.rd) |-> RDATA == 16'h0000;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray data");
  property p_align;
    s_read(RESULT_ADDR) |->
      (RDATA & ($past(align_q) ? 16'h003F : 16'hFC00)) == 16'h0000;
  endproperty
  a_align: assert property (p_align) else $error("bad layout");
  property p_rsvd;
    s_read(CONTROL_ADDR) |-> (RDATA & 16'h88CC) == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved set");
  // Read data shows flags of the read cycle, so compare the level there
  property p_irq_match;
    s_read(CONTROL_ADDR) |->
      $past(IRQ) == (RDATA[9] & RDATA[5] | RDATA[8] & RDATA[4]);
  endproperty
  a_irq_match: assert property (p_irq_match) else $error("irq");
  property p_irq_ie;
    IRQ |-> (ie_q | $past(ie_q)) != 2'h0;
  endproperty
  a_irq_ie: assert property (p_irq_ie) else $error("irq masked");
  property p_start;
    CORE_START |=> !CORE_START;
  endproperty
  a_start: assert property (p_start) else $error("long start");
  property p_sample;
    $rose(CORE_SAMPLE) |-> s_sampling;
  endproperty
  a_sample: assert property (p_sample) else $error("short sample");
  property p_stop;
    BUS.wr && BUS.addr == CONTROL_ADDR && !BUS.wdata[ENABLE_BIT]
      |-> ##2 !(CORE_SAMPLE || CORE_START);
  endproperty
  a_stop: assert property (p_stop) else $error("not idle");
endmodule
bind adc_seq_ctrl adc_seq_ctrl_sva chk_i (.CLK(CLK), .NRST(NRST), .BUS(BUS),
  .RDATA(RDATA), .IRQ(IRQ), .CORE_SAMPLE(CORE_SAMPLE),
  .CORE_START(CORE_START));

/* tb/adc_core_model.sv */
// Behavioural model of the analog conversion core
`timescale 1ns/1ns
module adc_core_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] delay,
  input  wire logic [2:0] channel,
  input  wire logic       start,
  output logic            ready,
  output logic [9:0]      data
);
  logic [7:0] cnt_q;
  logic [1:0] hold_q;
  logic       busy_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {cnt_q, hold_q, busy_q, ready, data} <= '0;
    end else begin
      ready <= 1'b0;
      if (start) begin
        busy_q <= 1'b1;
        cnt_q  <= delay;
      end else if (busy_q && cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        ready  <= 1'b1;
        hold_q <= 2'h3;
        data   <= {channel, 7'h5A};
      end else if (hold_q != 2'h0) begin
        hold_q <= hold_q - 2'h1;
      end else begin
        // Released data keeps toggling
        data <= ~data;
      end
    end
  end
endmodule

/* tb/adc_seq_ctrl_bench.sv */
// Register-level bench for the converter sequencer control block
`timescale 1ns/1ns
module adc_seq_ctrl_bench;
  import adc_seq_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  bus_req_type bus = '0;
  logic        tmr = 1'b0;
  logic        pin = 1'b0;
  logic [7:0]  delay = 8'h00;
  logic [15:0] rdata;
  logic        irq, ready, sample, start;
  logic [9:0]  data;
  logic [2:0]  channel;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          run_len = 0;
  int          last_len = 0;
  adc_seq_ctrl dut (.CLK(clk), .NRST(nrst), .BUS(bus), .RDATA(rdata),
    .IRQ(irq), .TIMER_TRIGGER(tmr), .EXTERNAL_TRIGGER_PIN(pin),
    .CORE_READY(ready), .CORE_DATA(data), .CORE_CHANNEL(channel),
    .CORE_SAMPLE(sample), .CORE_START(start));
  adc_core_model core (.clk(clk), .nrst(nrst), .delay(delay),
    .channel(channel), .start(start), .ready(ready), .data(data));
  initial begin
    forever #25 clk = ~clk;
  end
  // Length of the last sampling phase in bus cycles
  always @(posedge clk) begin
    if (sample === 1'b1) begin
      run_len++;
    end else if (run_len != 0) begin
      last_len = run_len;
      run_len = 0;
    end
  end
  task automatic chk(input logic [15:0] got, exp, mask);
    samples_checked++;
    if ((got & mask) !== (exp & mask)) begin
      n_fail++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, exp, mask = 16'hFFFF);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    chk(rdata, exp, mask);
    @(posedge clk);
  endtask
  task automatic pulse(input logic [1:0] which);
    {pin, tmr} <= which;
    repeat (2) @(posedge clk);
    {pin, tmr} <= 2'h0;
    @(posedge clk);
  endtask
  task automatic final_report();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(TRIGGER_ADDR, 16'h0007);
    rd(CONTROL_ADDR, 16'h0000);
    rd(DIVIDER_ADDR, 16'h0000);
    rd(16'h5388, 16'h0000);
    wr(RESULT_ADDR, 16'hFFFF);
    rd(RESULT_ADDR, 16'h0000);
    wr(TRIGGER_ADDR, 16'hFFFF);
    rd(TRIGGER_ADDR, 16'h3FF7);
    wr(DIVIDER_ADDR, 16'hFFFF);
    rd(DIVIDER_ADDR, 16'h000F);
    for (int i = 0; i < 2; i++) begin
      delay <= 8'(i * 20);
      wr(DIVIDER_ADDR, 16'(i));
      wr(TRIGGER_ADDR, 16'h2D00 | 16'(i * 16'h0087));
      wr(CONTROL_ADDR, 16'h0013);
      for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge clk);
      chk(16'((last_len - 1) / (2 << i)), 16'(1 + 7 * i), 16'hFFFF);
      rd(CONTROL_ADDR, 16'h5111);
      rd(RESULT_ADDR, i ? 16'hB680 : 16'h02DA);
      rd(CONTROL_ADDR, 16'h5011);
      chk({15'h0, irq}, 16'h0000, 16'hFFFF);
    end
    wr(TRIGGER_ADDR, 16'h0700);
    wr(CONTROL_ADDR, 16'h0023);
    for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge clk);
    repeat (4) @(posedge clk);
    rd(CONTROL_ADDR, 16'h0321);
    rd(RESULT_ADDR, 16'h005A);
    wr(CONTROL_ADDR, 16'h0021);
    rd(CONTROL_ADDR, 16'h0221);
    chk({15'h0, irq}, 16'h0001, 16'hFFFF);
    wr(CONTROL_ADDR, 16'h0201);
    rd(CONTROL_ADDR, 16'h0001);
    chk({15'h0, irq}, 16'h0000, 16'hFFFF);
    for (int s = 1; s < 4; s++) begin
      wr(TRIGGER_ADDR, 16'h0907 | 16'(s << 4));
      wr(CONTROL_ADDR, 16'h0003);
      pulse(s == 1 ? 2'h2 : (s == 2 ? 2'h3 : 2'h1));
      rd(CONTROL_ADDR, 16'h0003, 16'h0CFF);
      pulse(s == 1 ? 2'h1 : 2'h2);
      rd(CONTROL_ADDR, s == 2 ? 16'h0003 : 16'h0403, 16'h0CFF);
      wr(CONTROL_ADDR, 16'h0001);
      rd(CONTROL_ADDR, 16'h0001, 16'h0CFF);
    end
    // Continuous mode keeps running after the sequence end
    wr(TRIGGER_ADDR, 16'h0040);
    wr(CONTROL_ADDR, 16'h0013);
    for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge clk);
    rd(CONTROL_ADDR, 16'h0513, 16'h0FFF);
    wr(TRIGGER_ADDR, 16'h0907);
    wr(CONTROL_ADDR, 16'h0002);
    rd(CONTROL_ADDR, 16'h0002, 16'h0CFF);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end
endmodule
